//--- design/pfc_host.sv
// host controller that drives command sequences into a byte-wide parallel flash
// assumes flash pins are sampled synchronously and the flash answers within the strobe time
`include "pfc_consts.svh"
module pfc_host import pfc_pkg::*; #(
	parameter int ADDR_W = 23,
	parameter int STROBE_CYCLES = `PFC_STROBE_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire pfc_op_e cmd_op,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_accel,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_protected,
	output logic bypass_active,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic flash_acc,
	output logic [ADDR_W-1:0] flash_addr,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_in
);
	typedef enum logic [3:0] {
		PFC_ST_IDLE = 4'b0001,
		PFC_ST_SETUP = 4'b0010,
		PFC_ST_STROBE = 4'b0100,
		PFC_ST_RECOVER = 4'b1000
	} pfc_state_e;
	pfc_state_e state_reg;
	pfc_state_e state_next;
	pfc_op_e op_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0] data_reg;
	logic [2:0] step_reg;
	logic bypass_reg;
	logic timer_start;
	logic timer_done;
	logic [11:0] rom_addr;
	logic rom_user_hi;
	pfc_byte_t rom_data;
	logic rom_read;
	logic [2:0] rom_len;
	pfc_strobe_timer #(.CYCLES(STROBE_CYCLES)) u_timer (
		.clock(clock),
		.rst(rst),
		.start(timer_start),
		.done(timer_done)
	);
	pfc_seq_rom u_rom (
		.op(op_reg),
		.bypass(bypass_reg),
		.step(step_reg),
		.user_low(addr_reg[11:0]),
		.user_data(data_reg),
		.cyc_addr(rom_addr),
		.cyc_use_user_high(rom_user_hi),
		.cyc_data(rom_data),
		.cyc_read(rom_read),
		.cmd_len(rom_len)
	);
	// upper bits zero on fixed command addresses; flash ignores them anyway
	wire logic [ADDR_W-1:0] high_part = rom_user_hi ? addr_reg & ~ADDR_W'(`PFC_LOW_MASK)
		: {ADDR_W{1'b0}};
	wire logic [ADDR_W-1:0] cyc_full_addr = high_part | ADDR_W'(rom_addr);
	wire logic last_step = (step_reg == rom_len - 3'd1);
	wire logic accept = (state_reg == PFC_ST_IDLE) && cmd_valid;
	wire logic in_setup = (state_reg == PFC_ST_SETUP);
	wire logic in_strobe = (state_reg == PFC_ST_STROBE);
	wire logic in_recover = (state_reg == PFC_ST_RECOVER);
	wire logic seq_end = in_recover && timer_done && last_step;
	wire logic next_bypass = (op_reg == PFC_OP_BYPASS_ENTER) ? 1'b1
		: ((op_reg == PFC_OP_BYPASS_EXIT || op_reg == PFC_OP_RESET) ? 1'b0 : bypass_reg);
	assign timer_start = accept || (in_setup) || (in_strobe && timer_done)
		|| (in_recover && timer_done && !last_step);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PFC_ST_IDLE: if (cmd_valid) state_next = PFC_ST_SETUP;
			PFC_ST_SETUP: state_next = PFC_ST_STROBE;
			PFC_ST_STROBE: if (timer_done) state_next = PFC_ST_RECOVER;
			PFC_ST_RECOVER: begin
				if (timer_done) state_next = last_step ? PFC_ST_IDLE : PFC_ST_SETUP;
			end
			default: state_next = PFC_ST_IDLE;
		endcase
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= PFC_ST_IDLE;
			op_reg <= PFC_OP_READ;
			addr_reg <= '0;
			data_reg <= 8'h00;
			step_reg <= 3'd0;
			bypass_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				op_reg <= cmd_op;
				addr_reg <= cmd_addr;
				data_reg <= cmd_data;
			end
			if (accept)
				step_reg <= 3'd0;
			else if (in_recover && timer_done && !last_step)
				step_reg <= step_reg + 3'd1;
			if (seq_end)
				bypass_reg <= next_bypass;
		end
	end
	// pins: address, data and strobe all driven from the setup phase, strobe held for the timer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_addr <= '0;
			flash_dq_out <= 8'h00;
			flash_dq_oe <= 1'b0;
		end else begin
			if (in_setup) begin
				flash_addr <= cyc_full_addr;
				flash_dq_out <= rom_data;
				flash_dq_oe <= !rom_read;
				flash_ce_n <= 1'b0;
				flash_oe_n <= !rom_read;
				flash_we_n <= rom_read;
			end else if (in_strobe && timer_done) begin
				flash_oe_n <= 1'b1;
				flash_we_n <= 1'b1;
			end else if (seq_end) begin
				flash_ce_n <= 1'b1;
				flash_dq_oe <= 1'b0;
			end
		end
	end
	// accel follows the user request and is held until the sequence ends
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flash_acc <= 1'b0;
		end else if (accept) begin
			flash_acc <= cmd_accel;
		end else if (seq_end) begin
			flash_acc <= 1'b0;
		end
	end
	// read data captured at the end of the strobe, before output enable rises
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_protected <= 1'b0;
			cmd_ready <= 1'b0;
			bypass_active <= 1'b0;
		end else begin
			rsp_valid <= seq_end;
			cmd_ready <= (state_next == PFC_ST_IDLE) && !accept;
			bypass_active <= seq_end ? next_bypass : bypass_reg;
			if (in_strobe && timer_done && !flash_oe_n) begin
				rsp_data <= flash_dq_in;
				rsp_protected <= !flash_dq_in[`PFC_PROT_BIT];
			end
		end
	end
endmodule // pfc_host

//--- design/pfc_consts.svh
// command codes, unlock addresses and timing counts for the flash command host
// assumes a byte-wide parallel flash with 12 significant low address bits
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH
`define PFC_ADDR_UNLOCK1 12'hAAA
`define PFC_ADDR_UNLOCK2 12'h555
`define PFC_DATA_UNLOCK1 8'hAA
`define PFC_DATA_UNLOCK2 8'h55
`define PFC_CMD_RESET 8'hF0
`define PFC_CMD_AUTOSEL 8'h90
`define PFC_CMD_PROGRAM 8'hA0
`define PFC_CMD_ERASE 8'h80
`define PFC_CMD_CHIP 8'h10
`define PFC_CMD_SECTOR 8'h30
`define PFC_CMD_BYPASS 8'h20
`define PFC_CMD_BUF_LOAD 8'h25
`define PFC_CMD_BUF_CONFIRM 8'h29
`define PFC_CMD_STAT_READ 8'h70
`define PFC_CMD_STAT_CLEAR 8'h71
`define PFC_CMD_EXIT_ZERO 8'h00
`define PFC_LOW_PROTECT 12'h004
`define PFC_LOW_SECURE 12'h006
`define PFC_LOW_MASK 12'hFFF
`define PFC_PROT_BIT 0
`define PFC_STROBE_NS 100
`define PFC_CLK_NS 50
`define PFC_STROBE_CYC ((`PFC_STROBE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`endif

//--- design/pfc_pkg.sv
// types shared by the flash command host
// assumes nothing beyond the constants header
package pfc_pkg;
	typedef enum logic [3:0] {
		PFC_OP_READ = 4'h0,
		PFC_OP_RESET = 4'h1,
		PFC_OP_PROGRAM = 4'h2,
		PFC_OP_CHIP_ERASE = 4'h3,
		PFC_OP_SECTOR_ERASE = 4'h4,
		PFC_OP_PROTECT_VERIFY = 4'h5,
		PFC_OP_SECURE_VERIFY = 4'h6,
		PFC_OP_BUF_START = 4'h7,
		PFC_OP_BUF_WORD = 4'h8,
		PFC_OP_BUF_CONFIRM = 4'h9,
		PFC_OP_BUF_ABORT = 4'hA,
		PFC_OP_BYPASS_ENTER = 4'hB,
		PFC_OP_BYPASS_EXIT = 4'hC,
		PFC_OP_STAT_READ = 4'hD,
		PFC_OP_STAT_CLEAR = 4'hE
	} pfc_op_e;
	typedef logic [7:0] pfc_byte_t;
endpackage

//--- design/pfc_strobe_timer.sv
// cycle counter that spaces each bus strobe phase
// assumes nothing of start timing: a start while counting, as in the host's setup phase, reloads the count
`include "pfc_consts.svh"
module pfc_strobe_timer import pfc_pkg::*; #(
	parameter int CYCLES = `PFC_STROBE_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	output logic done
);
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic running_reg;
	wire logic last = running_reg && (count_reg == 8'h01);
	assign count_next = start ? CYCLES[7:0] : (running_reg ? count_reg - 8'h01 : count_reg);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_reg <= 8'h00;
			running_reg <= 1'b0;
			done <= 1'b0;
		end else begin
			count_reg <= count_next;
			running_reg <= start | (running_reg & ~last);
			done <= last;
		end
	end
endmodule // pfc_strobe_timer

//--- design/pfc_seq_rom.sv
// command sequence table: cycle address, data and read flag per operation
// assumes step counts from zero and cmd_len gives the steps of an operation
`include "pfc_consts.svh"
module pfc_seq_rom import pfc_pkg::*; (
	input wire pfc_op_e op,
	input wire logic bypass,
	input wire logic [2:0] step,
	input wire logic [11:0] user_low,
	input wire logic [7:0] user_data,
	output logic [11:0] cyc_addr,
	output logic cyc_use_user_high,
	output pfc_byte_t cyc_data,
	output logic cyc_read,
	output logic [2:0] cmd_len
);
	function automatic logic [20:0] unlock_step(input logic [2:0] s, input pfc_byte_t third);
		case (s)
			3'd0: unlock_step = {`PFC_ADDR_UNLOCK1, `PFC_DATA_UNLOCK1, 1'b0};
			3'd1: unlock_step = {`PFC_ADDR_UNLOCK2, `PFC_DATA_UNLOCK2, 1'b0};
			default: unlock_step = {`PFC_ADDR_UNLOCK1, third, 1'b0};
		endcase
	endfunction
	logic [20:0] row;
	logic user_hi;
	logic [2:0] len;
	always_comb begin
		row = {12'h000, 8'h00, 1'b1};
		user_hi = 1'b0;
		len = 3'd1;
		case (op)
			PFC_OP_READ: begin
				row = {user_low, 8'h00, 1'b1};
				user_hi = 1'b1;
			end
			PFC_OP_RESET: row = {`PFC_ADDR_UNLOCK1, `PFC_CMD_RESET, 1'b0};
			PFC_OP_PROGRAM: begin
				len = bypass ? 3'd2 : 3'd4;
				if (step == len - 3'd1) begin
					row = {user_low, user_data, 1'b0};
					user_hi = 1'b1;
				end else if (bypass)
					row = {`PFC_ADDR_UNLOCK1, `PFC_CMD_PROGRAM, 1'b0};
				else
					row = unlock_step(step, `PFC_CMD_PROGRAM);
			end
			PFC_OP_CHIP_ERASE, PFC_OP_SECTOR_ERASE: begin
				len = bypass ? 3'd2 : 3'd6;
				if (step == len - 3'd1) begin
					if (op == PFC_OP_CHIP_ERASE)
						row = {`PFC_ADDR_UNLOCK1, `PFC_CMD_CHIP, 1'b0};
					else begin
						row = {user_low, `PFC_CMD_SECTOR, 1'b0};
						user_hi = 1'b1;
					end
				end else if (bypass || step == 3'd2)
					row = {`PFC_ADDR_UNLOCK1, `PFC_CMD_ERASE, 1'b0};
				else
					// second unlock pair repeats AA then 55 at steps three and four
					row = unlock_step((step == 3'd1 || step == 3'd4) ? 3'd1 : 3'd0, 8'h00);
			end
			PFC_OP_PROTECT_VERIFY, PFC_OP_SECURE_VERIFY: begin
				len = 3'd4;
				if (step == 3'd3) begin
					row = {(op == PFC_OP_PROTECT_VERIFY) ? `PFC_LOW_PROTECT : `PFC_LOW_SECURE,
						8'h00, 1'b1};
					user_hi = (op == PFC_OP_PROTECT_VERIFY);
				end else
					row = unlock_step(step, `PFC_CMD_AUTOSEL);
			end
			PFC_OP_BUF_START: begin
				len = bypass ? 3'd2 : 3'd4;
				user_hi = (step >= len - 3'd2);
				if (step == len - 3'd1)
					row = {user_low, user_data, 1'b0};
				else if (step == len - 3'd2)
					row = {user_low, `PFC_CMD_BUF_LOAD, 1'b0};
				else
					row = unlock_step(step, 8'h00);
			end
			PFC_OP_BUF_WORD: begin
				row = {user_low, user_data, 1'b0};
				user_hi = 1'b1;
			end
			PFC_OP_BUF_CONFIRM: begin
				row = {user_low, `PFC_CMD_BUF_CONFIRM, 1'b0};
				user_hi = 1'b1;
			end
			PFC_OP_BUF_ABORT: begin
				len = 3'd3;
				row = unlock_step(step, `PFC_CMD_RESET);
			end
			PFC_OP_BYPASS_ENTER: begin
				len = 3'd3;
				row = unlock_step(step, `PFC_CMD_BYPASS);
			end
			PFC_OP_BYPASS_EXIT: begin
				len = 3'd2;
				row = {`PFC_ADDR_UNLOCK1, (step == 3'd0) ? `PFC_CMD_AUTOSEL
					: `PFC_CMD_EXIT_ZERO, 1'b0};
			end
			PFC_OP_STAT_READ: begin
				len = 3'd2;
				row = (step == 3'd0) ? {`PFC_ADDR_UNLOCK1, `PFC_CMD_STAT_READ, 1'b0}
					: {`PFC_ADDR_UNLOCK1, 8'h00, 1'b1};
			end
			PFC_OP_STAT_CLEAR: row = {`PFC_ADDR_UNLOCK1, `PFC_CMD_STAT_CLEAR, 1'b0};
			default: row = {`PFC_ADDR_UNLOCK1, `PFC_CMD_RESET, 1'b0};
		endcase
	end
	assign cyc_addr = row[20:9];
	assign cyc_data = row[8:1];
	assign cyc_read = row[0];
	assign cyc_use_user_high = user_hi;
	assign cmd_len = len;
endmodule // pfc_seq_rom

//--- bench/pfc_host_asserts.sv
// checker for the flash command host: strobe shape and handshake timing
// assumes it is bound to pfc_host and sees only that module's ports
module pfc_host_asserts import pfc_pkg::*; #(
	parameter int ADDR_W = 23,
	parameter int STROBE_CYCLES = 2
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_protected,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_dq_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// registered timer done holds each strobe one cycle past the count
	localparam int STROBE_SEEN = STROBE_CYCLES + 1;
	// a counter, since a repetition cannot take a parameter
	logic [7:0] low_cnt;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			low_cnt <= 8'h00;
		end else begin
			low_cnt <= (flash_oe_n && flash_we_n) ? 8'h00 : low_cnt + 8'h01;
		end
	end
	sequence s_take;
		cmd_valid && cmd_ready;
	endsequence
	sequence s_end;
		$rose(flash_ce_n);
	endsequence
	a_strobe_excl: assert property (!(!flash_oe_n && !flash_we_n))
		else $error("read and write strobes low together");
	a_write_drive: assert property (!flash_we_n |-> flash_dq_oe)
		else $error("write strobe without data drive");
	a_read_release: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("data driven during read");
	a_strobe_select: assert property ((!flash_oe_n || !flash_we_n) |-> !flash_ce_n)
		else $error("strobe without chip select");
	a_write_width: assert property ($rose(flash_we_n) |-> low_cnt == 8'(STROBE_SEEN))
		else $error("write strobe width wrong");
	a_read_width: assert property ($rose(flash_oe_n) |-> low_cnt == 8'(STROBE_SEEN))
		else $error("read strobe width wrong");
	// address and data change with the falling strobe, so hold is checked one cycle on
	a_write_hold: assert property (!flash_we_n |=>
		$stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved in write");
	a_take_once: assert property (s_take |=> !cmd_ready)
		else $error("ready stayed high after take");
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
	a_seq_done: assert property (s_end |-> ##[0:2] rsp_valid)
		else $error("no response after sequence end");
	a_prot_bit: assert property (rsp_valid |-> rsp_protected == !rsp_data[0])
		else $error("protection flag not inverse of bit zero");
	a_idle_quiet: assert property (cmd_ready |-> flash_ce_n && flash_oe_n && flash_we_n)
		else $error("bus active while idle");
endmodule // pfc_host_asserts

bind pfc_host pfc_host_asserts #(.ADDR_W(ADDR_W), .STROBE_CYCLES(STROBE_CYCLES)) u_asserts (
	.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_protected(rsp_protected),
	.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
	.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));

//--- bench/pfc_flash_model.sv
// behavioural byte-wide flash answering the host's bus cycles
// assumes strobes move on clock edges, so writes are taken at the clock
module pfc_flash_model import pfc_pkg::*; #(
	parameter int ADDR_W = 23,
	parameter int PROT_SECTOR = 3,
	parameter logic [7:0] SECURE_VAL = 8'h99,
	parameter logic [7:0] STATUS_VAL = 8'h80
) (
	input wire logic clock,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic acc,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] dq_out,
	output logic [7:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [20:0] wlog[$];
	logic [1:0] mode = 2'h0;
	logic [7:0] hist1 = 8'h00;
	logic [7:0] hist2 = 8'h00;
	logic we_q = 1'b1;
	logic [7:0] rd_val;
	wire logic [11:0] low = addr[11:0]; // upper command bits ignored
	wire logic is_prot = int'(addr[ADDR_W-1:16]) == PROT_SECTOR; // any address in sector
	always_comb begin
		case (mode)
			2'h1: rd_val = (low == 12'h004) ? {7'h00, is_prot}
				: (low == 12'h006) ? SECURE_VAL : 8'h00;
			2'h2: rd_val = STATUS_VAL;
			default: rd_val = addr[7:0] ^ 8'h5A;
		endcase
	end
	// deselected pins show the inverse so a late sample cannot pass
	assign dq_in = (ce_n || oe_n) ? ~rd_val : rd_val;
	always @(posedge clock) begin
		we_q <= we_n;
		if (!we_q && we_n && !ce_n) begin
			wlog.push_back({acc, low, dq_out});
			hist1 <= dq_out;
			hist2 <= hist1;
			if (dq_out == 8'hF0) begin
				mode <= 2'h0;
			end else if (dq_out == 8'h90 && hist1 == 8'h55 && hist2 == 8'hAA) begin
				mode <= 2'h1;
			end else if (dq_out == 8'h70 && low == 12'hAAA) begin
				mode <= 2'h2;
			end
		end
	end
endmodule // pfc_flash_model

//--- bench/parallel_flash_command_decoder_tb.sv
// self-checking bench for the flash command host against a behavioural flash
// assumes default strobe timing and a 20 MHz clock
module parallel_flash_command_decoder_tb import pfc_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [23:0] U1 = 24'h0AAAAA;
	localparam logic [23:0] U2 = 24'h055555;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	pfc_op_e cmd_op = PFC_OP_READ;
	logic [22:0] cmd_addr = 23'h000000;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_accel = 1'b0;
	logic cmd_ready, rsp_valid, rsp_protected, bypass_active;
	logic flash_ce_n, flash_oe_n, flash_we_n, flash_acc, flash_dq_oe;
	logic [22:0] flash_addr;
	logic [7:0] rsp_data, flash_dq_out, flash_dq_in;
	logic [20:0] ent;
	logic eacc = 1'b0;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	pfc_host dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_accel(cmd_accel), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_protected(rsp_protected),
		.bypass_active(bypass_active), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n), .flash_acc(flash_acc), .flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));
	pfc_flash_model mdl (.clock(clock), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
		.acc(flash_acc), .addr(flash_addr), .dq_out(flash_dq_out), .dq_in(flash_dq_in));
	initial begin
		forever #25 clock = ~clock;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkw(input logic [20:0] got, input logic [20:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: write %h expected %h", $time, got, exp);
		end
	endtask
	// entries flagged in bit 20 have a don't-care address
	task automatic es(input logic [23:0] s[$]);
		foreach (s[i]) begin
			ent = (mdl.wlog.size() > 0) ? mdl.wlog.pop_front() : 'x;
			if (s[i][20]) begin
				chk8(ent[7:0], s[i][7:0]);
			end else begin
				chkw(ent, {eacc, s[i][19:0]});
			end
		end
	endtask
	task automatic op(input pfc_op_e o, input logic [22:0] a, input logic [7:0] d);
		int n;
		chk8(8'(mdl.wlog.size()), 8'h00);
		for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_addr = a;
		cmd_data = d;
		cmd_accel = eacc;
		@(negedge clock);
		cmd_valid = 1'b0;
		for (n = 0; n < 400 && rsp_valid !== 1'b1; n++) @(negedge clock);
		chk8({7'h00, rsp_valid}, 8'h01);
	endtask
	task automatic back_to_read();
		op(PFC_OP_RESET, 23'h000000, 8'h00);
		es('{24'h1000F0});
	endtask
	initial begin
		repeat (16) @(negedge clock);
		chk8({3'h0, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, cmd_ready}, 8'h1C);
		rst = 1'b0;
		op(PFC_OP_READ, 23'h012345, 8'h00);
		chk8(rsp_data, 8'h1F);
		chk8({7'h00, rsp_protected}, 8'h00);
		eacc = 1'b1;
		op(PFC_OP_PROGRAM, 23'h000123, 8'h3C);
		es('{U1, U2, 24'h0AAAA0, 24'h01233C});
		eacc = 1'b0;
		op(PFC_OP_CHIP_ERASE, 23'h000000, 8'h00);
		es('{U1, U2, 24'h0AAA80, U1, U2, 24'h0AAA10});
		op(PFC_OP_SECTOR_ERASE, 23'h034567, 8'h00);
		es('{U1, U2, 24'h0AAA80, U1, U2, 24'h056730});
		for (int k = 2; k < 4; k++) begin
			op(PFC_OP_PROTECT_VERIFY, {k[6:0], 16'h1234}, 8'h00);
			es('{U1, U2, 24'h0AAA90});
			chk8(rsp_data, {7'h00, k == 3});
			chk8({7'h00, rsp_protected}, {7'h00, k != 3});
			back_to_read();
		end
		op(PFC_OP_SECURE_VERIFY, 23'h000000, 8'h00);
		es('{U1, U2, 24'h0AAA90});
		chk8(rsp_data, 8'h99);
		back_to_read();
		op(PFC_OP_BUF_START, 23'h005800, 8'h01);
		es('{U1, U2, 24'h080025, 24'h080001});
		for (int k = 0; k < 2; k++) begin
			op(PFC_OP_BUF_WORD, 23'h005810 + 23'(k), 8'hA1 + 8'(k));
			es('{{4'h0, 12'h810 + 12'(k), 8'hA1 + 8'(k)}});
		end
		op(PFC_OP_BUF_CONFIRM, 23'h005800, 8'h00);
		es('{24'h080029});
		op(PFC_OP_BUF_START, 23'h005800, 8'h00);
		es('{U1, U2, 24'h080025, 24'h080000});
		op(PFC_OP_BUF_ABORT, 23'h000000, 8'h00);
		es('{U1, U2, 24'h0AAAF0});
		op(PFC_OP_BYPASS_ENTER, 23'h000000, 8'h00);
		es('{U1, U2, 24'h0AAA20});
		chk8({7'h00, bypass_active}, 8'h01);
		op(PFC_OP_PROGRAM, 23'h000456, 8'h77);
		es('{24'h1000A0, 24'h045677});
		op(PFC_OP_SECTOR_ERASE, 23'h034567, 8'h00);
		es('{24'h100080, 24'h056730});
		op(PFC_OP_CHIP_ERASE, 23'h000000, 8'h00);
		es('{24'h100080, 24'h100010});
		op(PFC_OP_BYPASS_EXIT, 23'h000000, 8'h00);
		es('{24'h100090, 24'h100000});
		chk8({7'h00, bypass_active}, 8'h00);
		op(PFC_OP_STAT_READ, 23'h000000, 8'h00);
		es('{24'h0AAA70});
		chk8(rsp_data, 8'h80);
		op(PFC_OP_STAT_CLEAR, 23'h000000, 8'h00);
		es('{24'h0AAA71});
		back_to_read();
		summarize();
	end
endmodule // parallel_flash_command_decoder_tb
